// ### core/spi_pin_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PIN_MAP_SVH
`define SPI_PIN_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_DATA        8'h04
`define OFS_STATUS      8'h08
`define OFS_IRQ_EN      8'h0c
`define OFS_IRQ_CLR     8'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_MODULE_EN  0
`define CTRL_MASTER_EN  1
`define CTRL_SEL_LO     2
`define CTRL_SEL_HI     3
`define CTRL_RESET      32'h0000_0004

// ----------------------------------------------------------------------------
// Status fields: sticky events in [3:0], live state above
// ----------------------------------------------------------------------------
`define ST_DONE         0
`define ST_WCOL         1
`define ST_MODE_FAULT_FLAG         2
`define ST_RXOVRN       3
`define ST_TXFULL       4
`define ST_RXFULL       5
`define ST_BUSY         6
`define EVT_W           4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MCLK_NS         40
`define SCK_PERIOD_NS   320
`define SCK_HALF_CYC    ((`SCK_PERIOD_NS / `MCLK_NS) / 2)
`define BYTE_BITS       8

`endif

// ### core/spi_pin_pkg.sv
// Types shared by the serial port design files
package spi_pin_pkg;

    typedef enum logic [1:0] {
        SEL_3WIRE   = 2'b00,
        SEL_4W_IN   = 2'b01,
        SEL_OUT_LO  = 2'b10,
        SEL_OUT_HI  = 2'b11
    } select_mode_type;

    // Gray order along idle -> shift -> done
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_SHIFT = 2'b01,
        ENG_DONE  = 2'b11
    } engine_state_type;

endpackage : spi_pin_pkg

// ### core/pin_sample_if.sv
// Synchronised pin levels and edges passed from the sampler to the port core
`timescale 1ns/1ps
interface pin_sample_if;
    logic sck_lvl;
    logic sck_rise;
    logic nss_lvl;
    logic nss_fall;
    logic mosi_lvl;
    logic miso_lvl;

    modport producer (output sck_lvl, sck_rise, nss_lvl, nss_fall, mosi_lvl, miso_lvl);
    modport consumer (input  sck_lvl, sck_rise, nss_lvl, nss_fall, mosi_lvl, miso_lvl);
endinterface : pin_sample_if

// ### core/pin_sampler.sv
// Two-flop synchronisers and edge detection for the serial port input pins
`timescale 1ns/1ps
module pin_sampler (
    // Clock and reset
    input  wire logic  mclk_i,
    input  wire logic  rstn_i,
    // Raw pins
    input  wire logic  sck_i,
    input  wire logic  nss_i,
    input  wire logic  mosi_i,
    input  wire logic  miso_i,
    // Sampled view
    pin_sample_if.producer smp
);
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       sck_prev_q;
    logic       nss_prev_q;

    // ------------------------------------------------------------------------
    // Synchronisers; the first stage feeds nothing but the second
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 4'hf;
            sync_q <= 4'hf;
        end else begin
            meta_q <= {miso_i, mosi_i, nss_i, sck_i};
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Matches the synchroniser reset level so no false edge follows reset
            sck_prev_q <= 1'b1;
            nss_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sync_q[0];
            nss_prev_q <= sync_q[1];
        end
    end

    assign smp.sck_lvl  = sync_q[0];
    assign smp.sck_rise = sync_q[0] & ~sck_prev_q;
    assign smp.nss_lvl  = sync_q[1];
    assign smp.nss_fall = ~sync_q[1] & nss_prev_q;
    assign smp.mosi_lvl = sync_q[2];
    assign smp.miso_lvl = sync_q[3];
endmodule : pin_sampler

// ### core/serial_port.sv
// Serial port core: pin direction, select modes, shift engine and AHB-Lite registers
`timescale 1ns/1ps
`include "spi_pin_map.svh"

// Overview of operation
// - As master the port drives the master-out line from the shift register MSB, MSB first.
// - The master-in line is an input as master and an output carrying slave data as slave.
// - The master-in line floats when the port is disabled or is an unselected 4-wire slave.
// - As a 3-wire slave the master-in line is always driven from the shift register MSB.
// - The serial clock is generated and driven only as master and is an input as slave.
// - A 4-wire slave ignores every serial clock edge while its select input is high.
// - Mode 00 is 3-wire with the select pin unused and a slave permanently selected.
// - Mode 01 is 4-wire with the select pin an input that selects a slave when low.
// - A master in mode 01 gives up its master function on a falling select input.
// - Mode 1x drives the select pin as an output at the level of the lower mode bit.
// - The select signal is routed to a pin in every mode except 3-wire.
// - A select-caused master disable clears master and module enables and flags a fault.
// - A slave counts clock edges and after eight bits flags done and stores the byte unless the receive buffer is still full.
// - A master data write loads the transmit buffer, moving to an empty shifter at once.
module serial_port
    import spi_pin_pkg::*;
#(
    parameter int SCK_HALF = `SCK_HALF_CYC,
    parameter int DATA_W   = `BYTE_BITS
) (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    // AHB-Lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic [31:0]               hrdata_o,
    output logic                      hresp_o,
    // Serial pins
    input  wire logic                 sck_i,
    output logic                      sck_o,
    output logic                      sck_oe_o,
    input  wire logic                 mosi_i,
    output logic                      mosi_o,
    output logic                      mosi_oe_o,
    input  wire logic                 miso_i,
    output logic                      miso_o,
    output logic                      miso_oe_o,
    input  wire logic                 nss_i,
    output logic                      nss_o,
    output logic                      nss_oe_o,
    output logic                      nss_mapped_o,
    // Interrupt
    output logic                      irq_o
);
    import spi_pin_pkg::*;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_bad_half
        $error("SCK_HALF out of range");
    end
    if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W out of range");
    end

    localparam logic [7:0] HALF_CNT = 8'(SCK_HALF);
    localparam logic [5:0] BITS     = 6'(DATA_W);

    function automatic logic is_sel_in(input select_mode_type m);
        return (m == SEL_4W_IN);
    endfunction : is_sel_in

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    pin_sample_if smp ();

    pin_sampler u_sampler (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .sck_i  (sck_i),
        .nss_i  (nss_i),
        .mosi_i (mosi_i),
        .miso_i (miso_i),
        .smp    (smp.producer)
    );

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    select_mode_type       sel_mode_q;
    logic                  module_en_q;
    logic                  master_en_q;
    logic [`EVT_W-1:0]     status_q;
    logic [`EVT_W-1:0]     irq_en_q;
    logic [DATA_W-1:0]     txbuf_q;
    logic                  txfull_q;
    logic [DATA_W-1:0]     rxbuf_q;
    logic                  rxfull_q;
    logic [DATA_W-1:0]     shreg_q;
    logic [5:0]            bitcnt_q;
    logic [7:0]            div_q;
    logic                  sck_q;
    engine_state_type      state_q;
    logic                  dph_q;
    logic                  dph_wr_q;
    logic [7:0]            dph_addr_q;

    logic                  addr_ok;
    logic                  wr_ctrl;
    logic                  wr_data;
    logic                  wr_en;
    logic                  wr_clr;
    logic                  rd_data;
    logic                  is_master;
    logic                  selected;
    logic                  mode_fault;
    logic                  slave_edge;
    logic                  done_evt;
    logic                  wcol_evt;
    logic                  ovr_evt;
    logic                  master_tick;

    // ------------------------------------------------------------------------
    // AHB-Lite decode: zero wait states, always OKAY
    // ------------------------------------------------------------------------
    assign addr_ok = hsel_i & htrans_i[1] & hready_i;
    assign wr_ctrl = dph_q & dph_wr_q & (dph_addr_q == `OFS_CTRL);
    assign wr_data = dph_q & dph_wr_q & (dph_addr_q == `OFS_DATA);
    assign wr_en   = dph_q & dph_wr_q & (dph_addr_q == `OFS_IRQ_EN);
    assign wr_clr  = dph_q & dph_wr_q & (dph_addr_q == `OFS_IRQ_CLR);
    assign rd_data = addr_ok & ~hwrite_i & (haddr_i[7:0] == `OFS_DATA);
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dph_q      <= 1'b0;
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
        end else begin
            dph_q      <= addr_ok;
            dph_wr_q   <= hwrite_i;
            dph_addr_q <= haddr_i[7:0];
        end
    end

    // Read data is latched in the address phase so it stands through the data phase
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_ok && !hwrite_i) begin
            case (haddr_i[7:0])
                `OFS_CTRL:   hrdata_o <= {28'h0000_000, sel_mode_q, master_en_q, module_en_q};
                `OFS_DATA:   hrdata_o <= 32'(rxbuf_q);
                `OFS_STATUS: hrdata_o <= {25'h0000_000, (state_q != ENG_IDLE), rxfull_q,
                                          txfull_q, status_q};
                `OFS_IRQ_EN: hrdata_o <= {28'h0000_000, irq_en_q};
                default:     hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Role and selection
    // ------------------------------------------------------------------------
    assign is_master  = module_en_q & master_en_q;
    // Mode 00 slave is always selected; 1x as slave is unsupported and treated alike
    assign selected   = is_sel_in(sel_mode_q) ? ~smp.nss_lvl : 1'b1;
    assign mode_fault = is_master & is_sel_in(sel_mode_q) & smp.nss_fall;
    assign slave_edge = module_en_q & ~master_en_q & selected & smp.sck_rise;

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_mode_q  <= select_mode_type'(2'(`CTRL_RESET >> `CTRL_SEL_LO));
            module_en_q <= 1'b0;
            master_en_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                sel_mode_q  <= select_mode_type'(hwdata_i[`CTRL_SEL_HI:`CTRL_SEL_LO]);
                module_en_q <= hwdata_i[`CTRL_MODULE_EN];
                master_en_q <= hwdata_i[`CTRL_MASTER_EN];
            end
            // The fault wins over a same-cycle write so the bus is really released
            if (mode_fault) begin
                module_en_q <= 1'b0;
                master_en_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------------
    assign master_tick = (div_q == HALF_CNT - 8'h01);
    assign wcol_evt    = wr_data & txfull_q;
    assign done_evt    = (state_q == ENG_DONE) |
                         (slave_edge & (bitcnt_q == BITS - 6'h01));
    assign ovr_evt     = done_evt & ~master_en_q & rxfull_q;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            txbuf_q  <= '0;
            txfull_q <= 1'b0;
            shreg_q  <= '0;
            bitcnt_q <= 6'h00;
            div_q    <= 8'h00;
            sck_q    <= 1'b0;
            state_q  <= ENG_IDLE;
        end else begin
            if (wr_data && !txfull_q) begin
                txbuf_q  <= hwdata_i[DATA_W-1:0];
                txfull_q <= 1'b1;
            end
            if (!module_en_q || mode_fault) begin
                // Disabling is the only way to realign the 3-wire slave bit count
                bitcnt_q <= 6'h00;
                div_q    <= 8'h00;
                sck_q    <= 1'b0;
                state_q  <= ENG_IDLE;
            end else if (master_en_q) begin
                case (state_q)
                    ENG_IDLE: begin
                        if (txfull_q) begin
                            shreg_q  <= txbuf_q;
                            txfull_q <= 1'b0;
                            bitcnt_q <= 6'h00;
                            div_q    <= 8'h00;
                            state_q  <= ENG_SHIFT;
                        end
                    end
                    ENG_SHIFT: begin
                        div_q <= master_tick ? 8'h00 : div_q + 8'h01;
                        if (master_tick) begin
                            sck_q <= ~sck_q;
                            if (!sck_q) begin
                                shreg_q  <= {shreg_q[DATA_W-2:0], smp.miso_lvl};
                                bitcnt_q <= bitcnt_q + 6'h01;
                            end else if (bitcnt_q == BITS) begin
                                state_q <= ENG_DONE;
                            end
                        end
                    end
                    ENG_DONE: begin
                        state_q <= ENG_IDLE;
                    end
                    default: begin
                        state_q <= ENG_IDLE;
                    end
                endcase
            end else begin
                sck_q <= 1'b0;
                if (is_sel_in(sel_mode_q) && smp.nss_fall) begin
                    bitcnt_q <= 6'h00;
                end else if (slave_edge) begin
                    shreg_q  <= {shreg_q[DATA_W-2:0], smp.mosi_lvl};
                    bitcnt_q <= (bitcnt_q == BITS - 6'h01) ? 6'h00 : bitcnt_q + 6'h01;
                    state_q  <= (bitcnt_q == BITS - 6'h01) ? ENG_IDLE : ENG_SHIFT;
                end else if (state_q == ENG_IDLE && bitcnt_q == 6'h00 && txfull_q) begin
                    // Preload waits for a byte boundary so a running byte is not cut
                    shreg_q  <= txbuf_q;
                    txfull_q <= 1'b0;
                    state_q  <= ENG_SHIFT;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rxbuf_q  <= '0;
            rxfull_q <= 1'b0;
        end else if (done_evt && !ovr_evt) begin
            // Slave completes on the last edge, so the new bit joins here
            rxbuf_q  <= master_en_q ? shreg_q : {shreg_q[DATA_W-2:0], smp.mosi_lvl};
            rxfull_q <= 1'b1;
        end else if (rd_data) begin
            rxfull_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status: set wins over a same-cycle clear
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_q <= '0;
            irq_en_q <= '0;
        end else begin
            if (wr_en) begin
                irq_en_q <= hwdata_i[`EVT_W-1:0];
            end
            status_q <= (status_q & ~(wr_clr ? hwdata_i[`EVT_W-1:0] : '0))
                      | {ovr_evt, mode_fault, wcol_evt, done_evt};
        end
    end

    assign irq_o = |(status_q & irq_en_q);

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    assign sck_o        = sck_q;
    assign sck_oe_o     = is_master;
    assign mosi_o       = shreg_q[DATA_W-1];
    assign mosi_oe_o    = is_master;
    assign miso_o       = shreg_q[DATA_W-1];
    assign miso_oe_o    = module_en_q & ~master_en_q & selected;
    assign nss_o        = sel_mode_q[0];
    assign nss_oe_o     = sel_mode_q[1];
    assign nss_mapped_o = (sel_mode_q != SEL_3WIRE);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_fault_cause;
        is_master && sel_mode_q == SEL_4W_IN && smp.nss_fall;
    endsequence

    sequence s_fault_effect;
        !module_en_q && !master_en_q && status_q[`ST_MODE_FAULT_FLAG];
    endsequence

    a_miso_float: assert property (!module_en_q || master_en_q |-> !miso_oe_o)
        else $error("master-in driven while disabled or master");
    a_miso_unsel: assert property (sel_mode_q == SEL_4W_IN && smp.nss_lvl |-> !miso_oe_o)
        else $error("master-in driven by unselected slave");
    a_slave3_drive: assert property (module_en_q && !master_en_q && sel_mode_q == SEL_3WIRE
                                     |-> miso_oe_o && miso_o == shreg_q[DATA_W-1])
        else $error("3-wire slave not driving master-in");
    a_mosi_master: assert property (mosi_oe_o == is_master
                                    && (is_master -> mosi_o == shreg_q[DATA_W-1]))
        else $error("master-out drive wrong");
    a_sck_owner: assert property (!is_master |-> !sck_oe_o ##1 !sck_o)
        else $error("serial clock driven as slave");
    a_ignore_sck: assert property (module_en_q && !master_en_q && sel_mode_q == SEL_4W_IN
                                   && smp.nss_lvl |=> $stable(bitcnt_q))
        else $error("unselected slave shifted");
    a_fault_clear: assert property (s_fault_cause |=> s_fault_effect)
        else $error("mode fault did not disable the port");
    a_nss_out: assert property (sel_mode_q[1] |-> nss_oe_o && nss_o == sel_mode_q[0])
        else $error("select output level wrong");
    a_nss_steady: assert property (!wr_ctrl |=> $stable(nss_o))
        else $error("select output moved without a write");
    a_map_nss: assert property (nss_mapped_o == (sel_mode_q != SEL_3WIRE))
        else $error("select routing wrong");
    a_load_start: assert property (module_en_q && master_en_q && !mode_fault && !wr_ctrl
                                   && state_q == ENG_IDLE && txfull_q
                                   |=> state_q == ENG_SHIFT && !txfull_q)
        else $error("master did not start on loaded byte");
    a_done_eight: assert property (slave_edge && bitcnt_q == BITS - 6'h01 && !master_en_q
                                   |=> status_q[`ST_DONE] && rxfull_q)
        else $error("done flag not set after byte");
endmodule : serial_port

// ### sim/ext_master.sv
// Behavioural external serial master facing the port's slave side
`timescale 1ns/1ps
module ext_master (
    // Clock
    input  wire logic mclk_i,
    // Serial pins
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      nss_n_o
);
    initial begin
        sck_o = 1'h0;
        mosi_o = 1'h0;
        nss_n_o = 1'h1;
    end
    task automatic sel(input logic lvl);
        @(posedge mclk_i) nss_n_o <= lvl;
    endtask : sel
    // Clock stands low between frames; one bit per 8 system clocks
    task automatic xfer(input logic on, input logic [7:0] tx, output logic [7:0] rx);
        sel(!on);
        repeat (3) @(posedge mclk_i);
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= tx[i];
            repeat (4) @(posedge mclk_i);
            sck_o <= 1'h1;
            rx[i] = miso_i;
            repeat (4) @(posedge mclk_i);
            sck_o <= 1'h0;
        end
        repeat (4) @(posedge mclk_i);
        mosi_o <= ~mosi_o; // Released line must not show a stale bit
        sel(1'h1);
    endtask : xfer
endmodule : ext_master

// ### sim/spi_pin_mode_select_bench.sv
// Self-checking bench for the serial port select modes and pins
`timescale 1ns/1ps
module spi_pin_mode_select_bench;
    logic        mclk = 1'h0;
    logic        rstn_n = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] d;
    logic [7:0]  rx;
    logic [9:0]  rows [6] = '{10'h000, 10'h044, 10'h168, 10'h2db, 10'h3fb, 10'h0c3};
    int          miscompares = 0;
    int          num_checks = 0;
    int          n;
    wire         hready, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire         nss_o, nss_oe, mapped, irq, p_sck, p_mosi, p_nss_n, hresp;
    wire         sck_w = sck_oe ? sck_o : p_sck;
    wire         mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire         miso_w = miso_oe ? miso_o : mosi_w; // Loopback while master
    wire         nss_w = nss_oe ? nss_o : p_nss_n;
    wire [5:0]   pins = {nss_o, nss_oe, mapped, miso_oe, mosi_oe, sck_oe};

    always #20 mclk = ~mclk;

    serial_port uut (
        .mclk_i(mclk), .rstn_i(rstn_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_w),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_o(miso_oe), .nss_i(nss_w), .nss_o(nss_o), .nss_oe_o(nss_oe),
        .nss_mapped_o(mapped), .irq_o(irq));
    ext_master pm (
        .mclk_i(mclk), .miso_i(miso_w), .sck_o(p_sck), .mosi_o(p_mosi), .nss_n_o(p_nss_n));

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        k = 0;
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'h1 && ++k < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'h1 && ++k < 50);
        rd = hrdata;
        if (k >= 50) begin
            miscompares++;
            results;
        end
    endtask : bus

    initial begin
        repeat (5) @(posedge mclk);
        rstn_n <= 1'h1;
        @(posedge mclk);
        chk({25'h0, irq, pins}, 32'h28);
        bus(1'h0, 8'h00, 32'h0, d);
        chk(d, 32'h4);
        chk({31'h0, hresp}, 32'h0);
        bus(1'h0, 8'h20, 32'h0, d);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            bus(1'h1, 8'h00, {28'h0, rows[i][9:6]}, d);
            repeat (2) @(posedge mclk);
            chk({26'h0, pins}, {26'h0, rows[i][5:0]});
        end
        // Slave in 4-wire form: clocks with select high must not count
        bus(1'h1, 8'h00, 32'h5, d);
        pm.xfer(1'h0, 8'hff, rx);
        bus(1'h0, 8'h08, 32'h0, d);
        chk(d & 32'h1, 32'h0);
        bus(1'h1, 8'h04, 32'ha5, d);
        pm.xfer(1'h1, 8'h3c, rx);
        chk({24'h0, rx}, 32'ha5);
        bus(1'h0, 8'h04, 32'h0, d);
        chk(d, 32'h3c);
        chk({31'h0, irq}, 32'h0);
        bus(1'h1, 8'h0c, 32'h5, d);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'h1, 8'h10, 32'h1, d);
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        // Master with select driven low by software
        bus(1'h1, 8'h00, 32'hb, d);
        bus(1'h1, 8'h04, 32'h96, d);
        d = 32'h0;
        for (n = 0; n < 60 && d[0] !== 1'h1; n++)
            bus(1'h0, 8'h08, 32'h0, d);
        chk(d & 32'h1, 32'h1);
        if (d[0] !== 1'h1)
            results;
        chk({31'h0, nss_o}, 32'h0);
        bus(1'h0, 8'h04, 32'h0, d);
        chk(d, 32'h96);
        // Another master pulls select low while this one is enabled
        bus(1'h1, 8'h10, 32'h1, d);
        bus(1'h1, 8'h00, 32'h7, d);
        pm.sel(1'h0);
        repeat (6) @(posedge mclk);
        bus(1'h0, 8'h00, 32'h0, d);
        chk(d, 32'h4);
        bus(1'h0, 8'h08, 32'h0, d);
        chk(d & 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h1);
        pm.sel(1'h1);
        // Reset in mid-run must bring back the power-up pin state and mode
        rstn_n <= 1'h0;
        repeat (2) @(posedge mclk);
        rstn_n <= 1'h1;
        @(posedge mclk);
        chk({25'h0, irq, pins}, 32'h28);
        bus(1'h0, 8'h00, 32'h0, d);
        chk(d, 32'h4);
        results;
    end
endmodule : spi_pin_mode_select_bench
